// *** core/vdc_pkg.sv ***
// Purpose: Shared constants and types for the display command controller.
// Assumes: Commands arrive as whole bytes from the serial receiver.
// Notes:   Opcodes and register reset values live here; vdc_ctrl also codes field slices and output resets.
package vdc_pkg;
    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned ADDR_W       = 4;
    localparam int unsigned NUM_GRIDS    = 16;
    localparam int unsigned SYM_W        = 2;
    localparam int unsigned SEG_W        = 35;
    localparam int unsigned SCAN_SLOTS   = 16;
    localparam logic [2:0]  OP_CHAR_RAM  = 3'h0;
    localparam logic [2:0]  OP_GLYPH_RAM = 3'h1;
    localparam logic [2:0]  OP_SYM_RAM   = 3'h2;
    localparam logic [2:0]  OP_PORT      = 3'h3;
    localparam logic [2:0]  OP_DUTY      = 3'h4;
    localparam logic [2:0]  OP_DIGITS    = 3'h5;
    localparam logic [2:0]  OP_LIGHTS    = 3'h6;
    localparam logic [2:0]  OP_TEST      = 3'h7;
    localparam logic [7:0]  TEST_CODE    = 8'he0;
    localparam logic [1:0]  PORT_RESET   = 2'h3;
    localparam logic [2:0]  DUTY_RESET   = 3'h0;
    localparam logic [2:0]  DIGITS_RESET = 3'h0;
    localparam logic [4:0]  DUTY_BASE    = 5'h08;
    localparam logic [4:0]  DIGITS_BASE  = 5'h08;
    localparam logic [4:0]  DIGITS_ALL   = 5'h10;
    localparam int unsigned BIT_DISP_ON  = 3;
    localparam int unsigned BIT_STANDBY  = 2;
    localparam int unsigned BIT_ALL_ON   = 1;
    localparam int unsigned BIT_ALL_OFF  = 0;
    localparam logic [3:0]  LIGHTS_RESET = 4'h0;
    localparam logic [3:0]  SLOT_LAST    = 4'hf;
    localparam logic [7:0]  SLOT_LEN     = 8'h3f;

    typedef struct packed {
        logic             disp_on;
        logic             standby;
        logic             all_on;
        logic             all_off;
    } vdc_lights_t;

    typedef struct packed {
        logic             we;
        logic [ADDR_W-1:0] addr;
        logic [SYM_W-1:0]  data;
    } vdc_wr_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_CMD,
        RX_DATA,
        RX_SKIP
    } vdc_rx_state_t;
endpackage : vdc_pkg

// *** core/vdc_sym_ram.sv ***
// Purpose: Small symbol memory, one two-bit entry per digit position.
// Assumes: One write port and one read port on the same clock.
// Notes:   Read data is registered, so it lags the address by one cycle.
module vdc_sym_ram
    import vdc_pkg::*;
#(
    parameter int unsigned DEPTH = NUM_GRIDS,
    parameter int unsigned AW    = ADDR_W,
    parameter int unsigned DW    = SYM_W
) (
    input  wire logic          ref_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata_reg
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        rdata_reg <= mem[raddr];
    end
endmodule : vdc_sym_ram

// *** core/vdc_ctrl.sv ***
// Purpose: Serial command interpreter and output control for a 16-grid display driver.
// Assumes: Link select, shift clock and data are asynchronous pins, sampled on ref_clk.
// Notes:   Character and glyph memories and the scan waveform shaping live elsewhere.
// Notes on behaviour
// - Select low frames a transfer; bytes arrive LSB first on shift clock rises.
// - First byte is the command; bits 7 to 5 select the function.
// - Symbol write takes the start address, later bytes fill successive locations.
// - Symbol write command carries a four-bit digit address in bits 3 to 0.
// - Each symbol data byte supplies two bits in positions 1 and 0.
// - Symbol outputs come straight from symbol memory, not from character patterns.
// - After each symbol data byte the pointer advances by one.
// - Past the highest location the pointer wraps back to the start address.
// - Symbol address n belongs to grid n plus one.
// - Port command bit 1 loads port b, bit 0 loads port a.
// - A port pin is high for a stored one and low for a zero.
// - Both port bits are one after reset.
// - Duty value n gives a grid duty of eight plus n sixteenths.
// - Digit count zero scans all sixteen grids, n scans grids one to eight plus n.
// - Lights command: display-on bit 3, standby 2, all-on 1, all-off 0.
// - Standby forces segments, symbols and grids low and both ports high.
// - Display off forces segments, symbols, grids low; ports keep values; reset default.
// - All-on drives segments and symbols high while grids scan; all-off ignored.
// - All-off drives segments and symbols low while grids keep scanning.
// - Standby stops the oscillator while every setting keeps its value.
// - Display-on, all-on and all-off never change the port outputs.
// - A select falling edge wakes the device and restarts the oscillator.
// - Wake-up clears standby and display-on, giving display off.
// - The test command is accepted only while the test pin is high.
module vdc_ctrl
    import vdc_pkg::*;
#(
    parameter int unsigned GRIDS = NUM_GRIDS,
    parameter int unsigned SEGS  = SEG_W
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             link_sel_n,
    input  wire logic             link_sck,
    input  wire logic             link_data,
    input  wire logic             test_pin,
    input  wire logic [SEGS-1:0]  glyph_pattern,
    output logic [GRIDS-1:0]      grid_outputs,
    output logic [SEGS-1:0]       segment_outputs,
    output logic [SYM_W-1:0]      symbol_segment_outputs,
    output logic                  port_out_a,
    output logic                  port_out_b,
    output logic [ADDR_W-1:0]     scan_digit,
    output logic                  osc_run,
    output logic                  test_mode,
    output logic [BYTE_W-1:0]     char_wr_data,
    output logic [ADDR_W-1:0]     char_wr_addr,
    output logic                  char_wr_en
);
    // Two-stage synchronisers; the first stage is read only by the second.
    // The test strap is synchronised as well, since a board jumper may move at any time.
    // Reset values match the idle pin levels, so no false edge follows reset.
    logic [1:0] sel_meta_reg, sck_meta_reg, dat_meta_reg, tst_meta_reg;
    logic       sel_reg, sck_reg, dat_reg, tst_reg;
    logic       sel_prev_reg, sck_prev_reg;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sel_meta_reg <= 2'h3;
            sck_meta_reg <= 2'h0;
            dat_meta_reg <= 2'h0;
            tst_meta_reg <= 2'h0;
        end else begin
            sel_meta_reg <= {sel_meta_reg[0], link_sel_n};
            sck_meta_reg <= {sck_meta_reg[0], link_sck};
            dat_meta_reg <= {dat_meta_reg[0], link_data};
            tst_meta_reg <= {tst_meta_reg[0], test_pin};
        end
    end

    assign sel_reg = sel_meta_reg[1];
    assign sck_reg = sck_meta_reg[1];
    assign dat_reg = dat_meta_reg[1];
    assign tst_reg = tst_meta_reg[1];

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sel_prev_reg <= 1'b1;
            sck_prev_reg <= 1'b0;
        end else begin
            sel_prev_reg <= sel_reg;
            sck_prev_reg <= sck_reg;
        end
    end

    logic sel_fall, sck_rise, active;
    assign sel_fall = sel_prev_reg & ~sel_reg;
    assign sck_rise = ~sck_prev_reg & sck_reg & ~sel_reg;
    assign active   = ~sel_reg;

    // Byte assembly: shift in LSB first, a byte is done on its eighth bit.
    logic [BYTE_W-1:0] shift_reg;
    logic [2:0]        bit_cnt_reg;
    logic              byte_done;
    logic [BYTE_W-1:0] byte_val;

    assign byte_val  = {dat_reg, shift_reg[BYTE_W-1:1]};
    assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);

    always_ff @(posedge ref_clk) begin
        if (!resetn || !active) begin
            bit_cnt_reg <= 3'h0;
            shift_reg   <= '0;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg   <= byte_val;
        end
    end

    // Transfer state: first byte is the command, later ones are data for memory writes and are skipped otherwise.
    vdc_rx_state_t rx_reg;
    logic [2:0]    op_reg;

    always_ff @(posedge ref_clk) begin
        if (!resetn || !active) begin
            rx_reg <= RX_IDLE;
        end else begin
            unique case (rx_reg)
                RX_IDLE: begin
                    rx_reg <= RX_CMD;
                end
                RX_CMD: begin
                    if (byte_done) begin
                        rx_reg <= (byte_val[7:5] inside {OP_CHAR_RAM, OP_GLYPH_RAM,
                            OP_SYM_RAM}) ? RX_DATA : RX_SKIP;
                    end
                end
                RX_DATA: begin
                    rx_reg <= RX_DATA;
                end
                RX_SKIP: begin
                    rx_reg <= RX_SKIP;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            op_reg <= OP_CHAR_RAM;
        end else if (rx_reg == RX_CMD && byte_done) begin
            op_reg <= byte_val[7:5];
        end
    end

    logic cmd_done, data_done;
    assign cmd_done  = (rx_reg == RX_CMD) && byte_done;
    assign data_done = (rx_reg == RX_DATA) && byte_done;

    // Address pointers with wrap back to the start address.
    logic [ADDR_W-1:0] start_reg, ptr_reg;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            start_reg <= '0;
            ptr_reg   <= '0;
        end else if (cmd_done) begin
            start_reg <= byte_val[ADDR_W-1:0];
            ptr_reg   <= byte_val[ADDR_W-1:0];
        end else if (data_done) begin
            ptr_reg <= (ptr_reg == SLOT_LAST) ? start_reg : ptr_reg + 4'h1;
        end
    end

    vdc_wr_t sym_wr;
    always_comb begin
        sym_wr.we   = data_done && (op_reg == OP_SYM_RAM);
        sym_wr.addr = ptr_reg;
        sym_wr.data = byte_val[SYM_W-1:0];
    end

    // Character code writes are handed to the character memory outside.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            char_wr_en   <= 1'b0;
            char_wr_addr <= '0;
            char_wr_data <= '0;
        end else begin
            char_wr_en   <= data_done && (op_reg == OP_CHAR_RAM);
            char_wr_addr <= ptr_reg;
            char_wr_data <= byte_val;
        end
    end

    // Configuration registers.
    logic [1:0]  port_reg;
    logic [2:0]  duty_reg, digits_reg;
    vdc_lights_t lights_reg;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            port_reg <= PORT_RESET;
        end else if (cmd_done && byte_val[7:5] == OP_PORT) begin
            port_reg <= byte_val[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            duty_reg   <= DUTY_RESET;
            digits_reg <= DIGITS_RESET;
        end else begin
            if (cmd_done && byte_val[7:5] == OP_DUTY) begin
                duty_reg <= byte_val[2:0];
            end
            if (cmd_done && byte_val[7:5] == OP_DIGITS) begin
                digits_reg <= byte_val[2:0];
            end
        end
    end

    // Wake-up on select falling edge wins over a standby write in flight.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            lights_reg <= vdc_lights_t'(LIGHTS_RESET);
        end else if (sel_fall && lights_reg.standby) begin
            lights_reg.standby <= 1'b0;
            lights_reg.disp_on <= 1'b0;
        end else if (cmd_done && byte_val[7:5] == OP_LIGHTS) begin
            lights_reg <= vdc_lights_t'(byte_val[3:0]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            test_mode <= 1'b0;
        end else if (!tst_reg) begin
            test_mode <= 1'b0;
        end else if (cmd_done && byte_val == TEST_CODE) begin
            test_mode <= 1'b1;
        end
    end

    // Scan timing. Stopping the scan counter stands in for the stopped oscillator,
    // so every setting above is simply held while standby lasts.
    // A digit slot lasts SLOT_LEN plus one cycles, cut into sixteen sub-slots of four.
    logic [7:0]        tick_reg;
    logic [ADDR_W-1:0] slot_reg;
    logic [ADDR_W-1:0] slot_next;
    logic              slot_end;
    logic [4:0]        n_digits, duty_on;
    logic              run;

    assign run      = ~lights_reg.standby;
    assign slot_end = (tick_reg == SLOT_LEN);
    assign n_digits = (digits_reg == 3'h0) ? DIGITS_ALL
                                           : DIGITS_BASE + {2'h0, digits_reg};
    assign duty_on  = DUTY_BASE + {2'h0, duty_reg};

    // Symbol memory is read at the slot about to be shown, so that its registered
    // data lines up with the grid it belongs to.
    always_comb begin
        slot_next = slot_reg;
        if (run && slot_end) begin
            if ({1'b0, slot_reg} == n_digits - 5'h1) begin
                slot_next = '0;
            end else begin
                slot_next = slot_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tick_reg <= '0;
            slot_reg <= '0;
        end else if (run) begin
            tick_reg <= slot_end ? '0 : tick_reg + 8'h1;
            slot_reg <= slot_next;
        end
    end

    // The pulse is lit for duty_on of sixteen sub-slots of each digit slot.
    logic pulse_on;
    assign pulse_on = ({1'b0, tick_reg[5:2]} < duty_on);

    logic [SYM_W-1:0] sym_rd;
    vdc_sym_ram #(
        .DEPTH (NUM_GRIDS),
        .AW    (ADDR_W),
        .DW    (SYM_W)
    ) u_sym_ram (
        .ref_clk   (ref_clk),
        .we        (sym_wr.we),
        .waddr     (sym_wr.addr),
        .wdata     (sym_wr.data),
        .raddr     (slot_next),
        .rdata_reg (sym_rd)
    );

    // Output stage, registered; standby outranks every other light bit.
    logic [GRIDS-1:0] grid_next;
    logic [SEGS-1:0]  seg_next;
    logic [SYM_W-1:0] sym_next;

    always_comb begin
        grid_next = '0;
        grid_next[slot_reg] = pulse_on;
        seg_next  = glyph_pattern;
        sym_next  = sym_rd;
        if (lights_reg.standby) begin
            grid_next = '0;
            seg_next  = '0;
            sym_next  = '0;
        end else if (!lights_reg.disp_on) begin
            grid_next = '0;
            seg_next  = '0;
            sym_next  = '0;
        end else if (lights_reg.all_on) begin
            seg_next  = '1;
            sym_next  = '1;
        end else if (lights_reg.all_off) begin
            seg_next  = '0;
            sym_next  = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            grid_outputs           <= '0;
            segment_outputs        <= '0;
            symbol_segment_outputs <= '0;
            port_out_a             <= 1'b1;
            port_out_b             <= 1'b1;
            scan_digit             <= '0;
            osc_run                <= 1'b1;
        end else begin
            grid_outputs           <= grid_next;
            segment_outputs        <= seg_next;
            symbol_segment_outputs <= sym_next;
            port_out_a <= lights_reg.standby ? 1'b1 : port_reg[0];
            port_out_b <= lights_reg.standby ? 1'b1 : port_reg[1];
            scan_digit <= slot_reg;
            osc_run    <= run;
        end
    end
endmodule : vdc_ctrl

// *** testbench/vdc_chk.sv ***
// Purpose: Port-level assertions for the display command controller.
// Assumes: Sees only vdc_ctrl ports; the link pins are asynchronous.
// Notes:   Standby checks wait three cycles to let the output registers settle.
module vdc_chk
    import vdc_pkg::*;
#(
    parameter int unsigned GRIDS = NUM_GRIDS,
    parameter int unsigned SEGS  = SEG_W
) (
    input wire logic             ref_clk,
    input wire logic             resetn,
    input wire logic             link_sel_n,
    input wire logic             test_pin,
    input wire logic [GRIDS-1:0] grid_outputs,
    input wire logic [SEGS-1:0]  segment_outputs,
    input wire logic [SYM_W-1:0] symbol_segment_outputs,
    input wire logic             port_out_a,
    input wire logic             port_out_b,
    input wire logic [ADDR_W-1:0] scan_digit,
    input wire logic             osc_run,
    input wire logic             test_mode,
    input wire logic             char_wr_en
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking

    reset_state_a: assert property (!resetn |=> port_out_a && port_out_b
        && grid_outputs == '0 && segment_outputs == '0 && osc_run && !test_mode)
        else $error("reset state wrong");
    standby_out_a: assert property (disable iff (!resetn) !osc_run [*3] |->
        grid_outputs == '0 && segment_outputs == '0 && symbol_segment_outputs == '0
        && port_out_a && port_out_b) else $error("standby outputs wrong");
    grid_onehot_a: assert property (disable iff (!resetn) $onehot0(grid_outputs))
        else $error("more than one grid lit");
    grid_digit_a: assert property (disable iff (!resetn) grid_outputs != '0 |->
        grid_outputs == GRIDS'(1) << scan_digit) else $error("grid and digit disagree");
    wr_pulse_a: assert property (disable iff (!resetn) char_wr_en |=> !char_wr_en)
        else $error("write pulse too long");
    test_gate_a: assert property (disable iff (!resetn) $rose(test_mode) |-> test_pin)
        else $error("test mode without pin");
    port_hold_a: assert property (disable iff (!resetn) link_sel_n [*8] |=>
        $stable({port_out_a, port_out_b})) else $error("ports moved while idle");
    osc_hold_a: assert property (disable iff (!resetn) (!osc_run && link_sel_n) [*4]
        |=> !osc_run) else $error("oscillator woke by itself");
    wake_up_a: assert property (disable iff (!resetn) $fell(link_sel_n) && !osc_run
        |-> ##[1:8] osc_run) else $error("no wake on select");
    wake_blank_a: assert property (disable iff (!resetn) $rose(osc_run) |->
        (grid_outputs == '0) [*8]) else $error("display lit after wake");

    cover property (disable iff (!resetn) !osc_run);
    cover property (disable iff (!resetn) char_wr_en);
    cover property (disable iff (!resetn) test_mode);
endmodule : vdc_chk

bind vdc_ctrl vdc_chk #(.GRIDS(GRIDS), .SEGS(SEGS)) vdc_chk_i (.ref_clk(ref_clk),
    .resetn(resetn), .link_sel_n(link_sel_n), .test_pin(test_pin),
    .grid_outputs(grid_outputs), .segment_outputs(segment_outputs),
    .symbol_segment_outputs(symbol_segment_outputs), .port_out_a(port_out_a),
    .port_out_b(port_out_b), .scan_digit(scan_digit), .osc_run(osc_run),
    .test_mode(test_mode), .char_wr_en(char_wr_en));

// *** testbench/vdc_host.sv ***
// Purpose: Host model driving the three-wire link of the display controller.
// Assumes: Calls start just after a ref_clk edge; 80 ns halves keep that phase.
// Notes:   Released data shows the inverse bit, so a late sample never looks right.
module vdc_host (
    input  wire logic ref_clk,
    output logic      link_sel_n,
    output logic      link_sck,
    output logic      link_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        link_sel_n = 1'b1;
        link_sck   = 1'b0;
        link_data  = 1'b0;
    end
    task automatic open_f();
        @(posedge ref_clk);
        #1 link_sel_n = 1'b0;
        #80;
    endtask : open_f
    task automatic put_bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            link_data = b[i];
            #80 link_sck = 1'b1;
            #80 link_sck = 1'b0;
        end
    endtask : put_bits
    task automatic close_f();
        #80 link_sel_n = 1'b1;
        link_data = ~link_data;
    endtask : close_f
endmodule : vdc_host

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the display command controller.
// Assumes: A host model shifts commands; outputs are sampled 1 ns after edges.
// Notes:   Symbol memory is read back by sampling eight cycles after each grid lights.
module tb
    import vdc_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam int ADR[4] = '{0, 1, 14, 15};
    localparam int SY[4]  = '{0, 2, 3, 1};
    logic                ref_clk, resetn, test_pin, link_sel_n, link_sck, link_data;
    logic [SEG_W-1:0]    glyph_pattern, segment_outputs;
    logic [NUM_GRIDS-1:0] grid_outputs;
    logic [SYM_W-1:0]    symbol_segment_outputs;
    logic                port_out_a, port_out_b, osc_run, test_mode, char_wr_en;
    logic [ADDR_W-1:0]   scan_digit, char_wr_addr, wr_addr;
    logic [7:0]          char_wr_data, wr_data;
    int                  miscompares = 0, checks = 0, cyc = 0, wr_cnt = 0;

    vdc_ctrl vdc_ctrl_i (.ref_clk(ref_clk), .resetn(resetn), .link_sel_n(link_sel_n),
        .link_sck(link_sck), .link_data(link_data), .test_pin(test_pin),
        .glyph_pattern(glyph_pattern), .grid_outputs(grid_outputs),
        .segment_outputs(segment_outputs), .symbol_segment_outputs(symbol_segment_outputs),
        .port_out_a(port_out_a), .port_out_b(port_out_b), .scan_digit(scan_digit),
        .osc_run(osc_run), .test_mode(test_mode), .char_wr_data(char_wr_data),
        .char_wr_addr(char_wr_addr), .char_wr_en(char_wr_en));
    vdc_host vdc_host_i (.ref_clk(ref_clk), .link_sel_n(link_sel_n), .link_sck(link_sck),
        .link_data(link_data));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (char_wr_en === 1'b1) begin
            wr_cnt++;
            wr_addr = char_wr_addr;
            wr_data = char_wr_data;
        end
        if (cyc == 80000) begin
            miscompares++;
            results();
        end
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic xfer(input logic [31:0] w, input int n);
        vdc_host_i.open_f();
        for (int i = 0; i < n; i++) vdc_host_i.put_bits(w[8*i +: 8], 8);
        vdc_host_i.close_f();
        tick(8);
    endtask : xfer
    task automatic seek(input int k);
        int n;
        n = 0;
        while (grid_outputs[k] !== 1'b1 && n < 4096) begin
            tick(1);
            n++;
        end
        check("grid lit", n < 4096, 1);
        tick(8);
    endtask : seek

    initial begin
        logic [15:0] seen;
        int          n;
        resetn = 1'b0;
        test_pin = 1'b0;
        glyph_pattern = 35'h2_aaaa_aaaa;
        tick(16);
        resetn = 1'b1;
        tick(4);
        check("ports", {port_out_b, port_out_a}, 2'h3);
        check("grids", grid_outputs, 16'h0);
        for (int v = 0; v < 4; v++) begin
            xfer(32'h7c | v, 1);
            check("ports", {port_out_b, port_out_a}, v[1:0]);
        end
        xfer(32'h61, 1);
        xfer(32'h02_00_40, 3);
        xfer(32'h03_fd_fe_4e, 4);
        vdc_host_i.open_f();
        vdc_host_i.put_bits(8'h41, 8);
        vdc_host_i.put_bits(8'hff, 5);
        vdc_host_i.close_f();
        xfer(32'h33_22_11_0e, 4);
        check("char writes", {wr_cnt[7:0], wr_addr, wr_data}, 20'h03_e33);
        xfer(32'hc8, 1);
        for (int i = 0; i < 4; i++) begin
            seek(ADR[i]);
            check("symbol", symbol_segment_outputs, SY[i]);
            check("segments", segment_outputs, 35'h2_aaaa_aaaa);
        end
        for (int l = 9; l < 12; l++) begin
            xfer(32'hc0 | l, 1);
            seek(3);
            check("segments", segment_outputs, l == 9 ? 64'h0 : 64'h7_ffff_ffff);
            check("symbols", symbol_segment_outputs, l == 9 ? 2'h0 : 2'h3);
            check("ports", {port_out_b, port_out_a}, 2'h1);
        end
        xfer(32'hc0, 1);
        tick(80);
        check("display off", {grid_outputs, segment_outputs}, 0);
        check("ports", {port_out_b, port_out_a}, 2'h1);
        xfer(32'hcc, 1);
        tick(16);
        check("standby", {osc_run, port_out_b, port_out_a, grid_outputs}, 19'h3_0000);
        vdc_host_i.open_f();
        vdc_host_i.close_f();
        tick(8);
        check("awake", {osc_run, port_out_b, port_out_a}, 3'h5);
        seen = '0;
        repeat (200) begin
            tick(1);
            seen |= grid_outputs;
        end
        check("blank after wake", seen, 16'h0);
        xfer(32'hc8, 1);
        seek(1);
        check("symbol kept", symbol_segment_outputs, 2'h2);
        for (int k = 0; k < 8; k += 7) begin
            xfer(32'ha0 | k, 1);
            seen = '0;
            repeat (2048) begin
                tick(1);
                seen |= grid_outputs;
            end
            check("scanned", seen, k == 0 ? 16'hffff : 16'(32'h1 << (8 + k)) - 16'h1);
        end
        for (int d = 0; d < 8; d += 7) begin
            xfer(32'h80 | d, 1);
            while (grid_outputs[0] === 1'b1) begin
                tick(1);
            end
            n = 0;
            while (grid_outputs[0] !== 1'b1 && n < 4096) begin
                tick(1);
                n++;
            end
            n = 0;
            while (grid_outputs[0] === 1'b1 && n < 100) begin
                tick(1);
                n++;
            end
            check("duty", n, (8 + d) * 4);
        end
        xfer(32'he0, 1);
        check("test mode", test_mode, 1'b0);
        test_pin = 1'b1;
        xfer(32'he0, 1);
        check("test mode", test_mode, 1'b1);
        results();
    end
endmodule : tb
